// ==== pca_pkg.sv ====
package pca_pkg;
  localparam int SAMPLE_W = 16;
  localparam int CAL_W    = 16;
  localparam int CUR_W    = 16;
  localparam int PWR_W    = 24;
  localparam int AVG_SEL_W = 3;
  localparam int AVG_MAX  = 1024;
  localparam int MUL_W    = 32;

  // Averaging count selector: index to sample count
  localparam logic [AVG_SEL_W-1:0] AVG_SEL_ONE = 3'h0;

  typedef enum logic [1:0] {
    PCA_CH_SHUNT = 2'b00,
    PCA_CH_BUS   = 2'b01,
    PCA_CH_TEMP  = 2'b10
  } pca_chan_type;

  typedef struct packed {
    pca_chan_type          chan;
    logic [SAMPLE_W-1:0]   data;
  } pca_sample_type;

  typedef struct packed {
    logic signed [CUR_W-1:0] current;
    logic signed [PWR_W-1:0] power;
  } pca_result_type;

  localparam logic [CUR_W-1:0] CUR_RESET = 16'h0000;
  localparam logic [PWR_W-1:0] PWR_RESET = 24'h000000;
  localparam int CUR_SHIFT = 11;
  localparam int PWR_SHIFT = 8;
endpackage

// ==== pca_mult.sv ====
`timescale 1ns/100ps
module pca_mult #(
  parameter int A_W = 16,
  parameter int B_W = 16
) (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     start,
  input  wire logic signed [A_W-1:0]    a,
  input  wire logic signed [B_W-1:0]    b,
  output logic                          done,
  output logic signed [A_W+B_W-1:0]     product
);
  // One-cycle registered product; keeps the multiplier off the accumulate path
  logic                         next_done;
  logic signed [A_W+B_W-1:0]    next_product;

  always_comb begin
    next_done    = start;
    next_product = start ? a * b : product;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      done    <= 1'b0;
      product <= '0;
    end else begin
      done    <= next_done;
      product <= next_product;
    end
  end
endmodule // pca_mult

// ==== pca_engine.sv ====
`timescale 1ns/100ps
module pca_engine #(
  parameter int AVG_LIMIT = pca_pkg::AVG_MAX
) (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              sample_valid,
  input  wire pca_pkg::pca_sample_type           sample,
  input  wire logic [pca_pkg::CAL_W-1:0]         shunt_cal,
  input  wire logic [pca_pkg::AVG_SEL_W-1:0]     avg_sel,
  input  wire logic                              run_restart,
  output logic [1:0]                             mux_sel,
  output pca_pkg::pca_result_type                result,
  output logic                                   result_valid,
  output logic                                   run_done
);
  localparam int ACC_CW = pca_pkg::CUR_W + 11;
  localparam int ACC_PW = pca_pkg::PWR_W + 11;
  localparam int MW     = pca_pkg::MUL_W;

  if (AVG_LIMIT < 1 || AVG_LIMIT > pca_pkg::AVG_MAX) begin : g_bad_limit
    $error("AVG_LIMIT out of range");
  end

  // Selector codes 0..7 give 1,4,16,64,128,256,512,1024 as log2 shift
  function automatic logic [3:0] avg_log2(input logic [pca_pkg::AVG_SEL_W-1:0] s);
    unique case (s)
      3'h0: avg_log2 = 4'h0;
      3'h1: avg_log2 = 4'h2;
      3'h2: avg_log2 = 4'h4;
      3'h3: avg_log2 = 4'h6;
      3'h4: avg_log2 = 4'h7;
      3'h5: avg_log2 = 4'h8;
      3'h6: avg_log2 = 4'h9;
      3'h7: avg_log2 = 4'hA;
    endcase
  endfunction

  typedef enum logic [1:0] {
    PCA_IDLE = 2'b00,
    PCA_CUR  = 2'b01,
    PCA_PWR  = 2'b10,
    PCA_ACC  = 2'b11
  } pca_state_type;

  pca_state_type               state;
  pca_state_type               next_state;
  logic [pca_pkg::SAMPLE_W-1:0] shunt_hold;
  logic [pca_pkg::SAMPLE_W-1:0] next_shunt_hold;
  logic [pca_pkg::SAMPLE_W-1:0] bus_hold;
  logic [pca_pkg::SAMPLE_W-1:0] next_bus_hold;
  logic                        have_shunt;
  logic                        next_have_shunt;
  logic signed [pca_pkg::CUR_W-1:0] cur_prev;
  logic signed [pca_pkg::CUR_W-1:0] next_cur_prev;
  logic signed [ACC_CW-1:0]    acc_cur;
  logic signed [ACC_CW-1:0]    next_acc_cur;
  logic signed [ACC_PW-1:0]    acc_pwr;
  logic signed [ACC_PW-1:0]    next_acc_pwr;
  logic [10:0]                 count;
  logic [10:0]                 next_count;
  logic [1:0]                  next_mux_sel;
  pca_pkg::pca_result_type     next_result;
  logic                        next_result_valid;
  logic                        next_run_done;
  logic signed [pca_pkg::CUR_W-1:0] cur_new;
  logic signed [pca_pkg::CUR_W-1:0] next_cur_new;
  logic signed [pca_pkg::PWR_W-1:0] pwr_new;
  logic signed [pca_pkg::PWR_W-1:0] next_pwr_new;

  logic                        mul_start;
  logic signed [15:0]          mul_a;
  logic signed [15:0]          mul_b;
  logic                        mul_done;
  logic signed [MW-1:0]        mul_p;

  pca_mult #(.A_W(16), .B_W(16)) u_mult (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (mul_start),
    .a        (mul_a),
    .b        (mul_b),
    .done     (mul_done),
    .product  (mul_p)
  );

  logic [10:0] target;
  logic [3:0]  shift;
  always_comb begin
    shift  = avg_log2(avg_sel);
    target = 11'(1) << shift;
  end

  always_comb begin
    next_state        = state;
    next_shunt_hold   = shunt_hold;
    next_bus_hold     = bus_hold;
    next_have_shunt   = have_shunt;
    next_cur_prev     = cur_prev;
    next_cur_new      = cur_new;
    next_pwr_new      = pwr_new;
    next_acc_cur      = acc_cur;
    next_acc_pwr      = acc_pwr;
    next_count        = count;
    next_mux_sel      = mux_sel;
    next_result       = result;
    next_result_valid = 1'b0;
    next_run_done     = 1'b0;
    mul_start         = 1'b0;
    mul_a             = '0;
    mul_b             = '0;
    // Samples are captured in any state, so the converter never waits
    if (sample_valid) begin
      unique case (sample.chan)
        pca_pkg::PCA_CH_SHUNT: begin
          next_shunt_hold = sample.data;
          next_have_shunt = 1'b1;
          next_mux_sel    = 2'(pca_pkg::PCA_CH_BUS);
        end
        pca_pkg::PCA_CH_BUS: begin
          next_bus_hold = sample.data;
          next_mux_sel  = 2'(pca_pkg::PCA_CH_TEMP);
          if (have_shunt && state == PCA_IDLE) begin
            next_have_shunt = 1'b0;
            next_state      = PCA_CUR;
          end
        end
        default: next_mux_sel = 2'(pca_pkg::PCA_CH_SHUNT);
      endcase
    end
    unique case (state)
      PCA_IDLE: ;
      PCA_CUR: begin
        // Power first, from the current held before this pair
        mul_start = 1'b1;
        mul_a     = cur_prev;
        mul_b     = $signed({1'b0, bus_hold[14:0]});
        next_state = PCA_PWR;
      end
      PCA_PWR: begin
        if (mul_done) begin
          next_pwr_new = (shunt_cal == '0) ? '0 :
                         pca_pkg::PWR_W'(mul_p >>> pca_pkg::PWR_SHIFT);
          mul_start = 1'b1;
          mul_a     = $signed(shunt_hold);
          mul_b     = $signed({1'b0, shunt_cal[14:0]});
          next_state = PCA_ACC;
        end
      end
      PCA_ACC: begin
        if (mul_done) begin
          next_cur_new  = pca_pkg::CUR_W'(mul_p >>> pca_pkg::CUR_SHIFT);
          next_cur_prev = pca_pkg::CUR_W'(mul_p >>> pca_pkg::CUR_SHIFT);
          if (avg_sel == pca_pkg::AVG_SEL_ONE) begin
            next_result.current = pca_pkg::CUR_W'(mul_p >>> pca_pkg::CUR_SHIFT);
            next_result.power   = pwr_new;
            next_result_valid   = 1'b1;
            next_run_done       = 1'b1;
            next_count          = '0;
            next_acc_cur        = '0;
            next_acc_pwr        = '0;
          end else begin
            next_acc_cur = acc_cur + ACC_CW'(pca_pkg::CUR_W'(mul_p >>> pca_pkg::CUR_SHIFT));
            next_acc_pwr = acc_pwr + ACC_PW'(pwr_new);
            next_count   = count + 11'(1);
            if (count + 11'(1) >= target) begin
              // Power of two counts make the divide a shift
              next_result.current = pca_pkg::CUR_W'(next_acc_cur >>> shift);
              next_result.power   = pca_pkg::PWR_W'(next_acc_pwr >>> shift);
              next_result_valid   = 1'b1;
              next_run_done       = 1'b1;
              next_count          = '0;
              next_acc_cur        = '0;
              next_acc_pwr        = '0;
            end
          end
          next_state = PCA_IDLE;
        end
      end
    endcase
    if (run_restart) begin
      // Restart abandons the partial run; result keeps the last full value, mux_sel goes back to shunt
      next_count      = '0;
      next_acc_cur    = '0;
      next_acc_pwr    = '0;
      next_have_shunt = 1'b0;
      next_state      = PCA_IDLE;
      next_mux_sel    = 2'(pca_pkg::PCA_CH_SHUNT);
      // A run finishing in the restart cycle is dropped too, not published
      next_result       = result;
      next_result_valid = 1'b0;
      next_run_done     = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state        <= PCA_IDLE;
      shunt_hold   <= '0;
      bus_hold     <= '0;
      have_shunt   <= 1'b0;
      cur_prev     <= '0;
      cur_new      <= '0;
      pwr_new      <= '0;
      acc_cur      <= '0;
      acc_pwr      <= '0;
      count        <= '0;
      mux_sel      <= 2'(pca_pkg::PCA_CH_SHUNT);
      result       <= {pca_pkg::CUR_RESET, pca_pkg::PWR_RESET};
      result_valid <= 1'b0;
      run_done     <= 1'b0;
    end else begin
      state        <= next_state;
      shunt_hold   <= next_shunt_hold;
      bus_hold     <= next_bus_hold;
      have_shunt   <= next_have_shunt;
      cur_prev     <= next_cur_prev;
      cur_new      <= next_cur_new;
      pwr_new      <= next_pwr_new;
      acc_cur      <= next_acc_cur;
      acc_pwr      <= next_acc_pwr;
      count        <= next_count;
      mux_sel      <= next_mux_sel;
      result       <= next_result;
      result_valid <= next_result_valid;
      run_done     <= next_run_done;
    end
  end
endmodule // pca_engine

// ==== pca_checker.sv ====
`timescale 1ns/100ps
module pca_checker #(
  parameter int AVG_LIMIT = 1024
) (
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  input wire logic                    sample_valid,
  input wire pca_pkg::pca_sample_type sample,
  input wire logic [15:0]             shunt_cal,
  input wire logic [2:0]              avg_sel,
  input wire logic                    run_restart,
  input wire logic [1:0]              mux_sel,
  input wire pca_pkg::pca_result_type result,
  input wire logic                    result_valid,
  input wire logic                    run_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire bus_take = sample_valid && sample.chan == pca_pkg::PCA_CH_BUS;
  wire one_avg = avg_sel == pca_pkg::AVG_SEL_ONE;
  a_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("result_valid held past one cycle");
  a_done_same: assert property (run_done == result_valid)
    else $error("run_done differs from result_valid");
  a_result_hold: assert property (!result_valid |-> $stable(result))
    else $error("result moved without result_valid");
  a_single_latency: assert property (result_valid && one_avg |-> $past(bus_take, 4))
    else $error("single result not 4 cycles after bus sample");
  a_cal_zero: assert property (result_valid && shunt_cal == 16'h0000 |-> result.power == 24'h0)
    else $error("power not zero with zero calibration");
  a_mux_shunt: assert property (sample_valid && sample.chan == pca_pkg::PCA_CH_SHUNT |=> mux_sel == 2'h1)
    else $error("mux did not step to bus");
  a_mux_bus: assert property (bus_take |=> mux_sel == 2'h2)
    else $error("mux did not step to temperature");
  a_mux_hold: assert property (!sample_valid && !run_restart |=> $stable(mux_sel))
    else $error("mux moved without a sample");
  a_restart_mux: assert property (run_restart |=> mux_sel == 2'h0)
    else $error("mux not back to shunt after restart");
  a_restart_keep: assert property (run_restart |=> !result_valid && $stable(result))
    else $error("result changed by restart");
  a_reset_clear: assert property ($fell(sys_rst) |-> result == '0 && mux_sel == 2'h0)
    else $error("outputs not clear after reset");
  a_restart_quiet: assert property (run_restart && !one_avg |=> !result_valid [*8])
    else $error("result soon after restart");
  c_single: cover property (result_valid && one_avg);
  c_long: cover property (result_valid && avg_sel == 3'h7);
  c_restart: cover property (run_restart);
endmodule // pca_checker

bind pca_engine pca_checker #(.AVG_LIMIT(AVG_LIMIT)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .sample_valid(sample_valid), .sample(sample),
  .shunt_cal(shunt_cal), .avg_sel(avg_sel), .run_restart(run_restart), .mux_sel(mux_sel),
  .result(result), .result_valid(result_valid), .run_done(run_done));

// ==== pca_adc_model.sv ====
`timescale 1ns/100ps
module pca_adc_model #(
  parameter int CONV = 8
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [1:0]        mux_sel,
  input  wire logic [15:0]       shunt_val,
  input  wire logic [15:0]       bus_val,
  output logic                   sample_valid,
  output pca_pkg::pca_sample_type sample
);
  logic [7:0]              cnt;
  logic [7:0]              next_cnt;
  logic                    next_valid;
  pca_pkg::pca_sample_type next_sample;
  always_comb begin
    // Fixed pace: the converter never waits for the arithmetic
    next_cnt = (cnt == 8'(CONV - 1)) ? 8'h00 : cnt + 8'h01;
    next_valid = (cnt == 8'(CONV - 1));
    next_sample.chan = pca_pkg::pca_chan_type'(mux_sel);
    // Idle data flips so a stale value never passes as fresh
    next_sample.data = ~sample.data;
    if (next_valid) begin
      case (mux_sel)
        2'h0:    next_sample.data = shunt_val;
        2'h1:    next_sample.data = bus_val;
        default: next_sample.data = 16'h0C80;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt <= 8'h00;
      sample_valid <= 1'b0;
      sample <= '0;
    end else begin
      cnt <= next_cnt;
      sample_valid <= next_valid;
      sample <= next_sample;
    end
  end
endmodule // pca_adc_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module tb_top;
  localparam int PAIR = 24;
  logic                    core_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic [15:0]             shunt_val = 16'h0400;
  logic [15:0]             bus_val = 16'h0300;
  logic [15:0]             shunt_cal = 16'h0100;
  logic [2:0]              avg_sel = 3'h0;
  logic                    run_restart = 1'b0;
  logic                    sample_valid;
  logic [1:0]              mux_sel;
  logic                    result_valid;
  logic                    run_done;
  pca_pkg::pca_sample_type sample;
  pca_pkg::pca_result_type result;
  int                      failures = 0;
  int                      checks = 0;
  int                      bus_cnt = 0;
  longint                  prev_cur = 0;
  int                      sh_tab[8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (sample_valid && sample.chan == pca_pkg::PCA_CH_BUS) bus_cnt++;
  pca_adc_model #(.CONV(8)) adc (.core_clk(core_clk), .sys_rst(sys_rst), .mux_sel(mux_sel),
    .shunt_val(shunt_val), .bus_val(bus_val), .sample_valid(sample_valid), .sample(sample));
  pca_engine dut (.core_clk(core_clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
    .sample(sample), .shunt_cal(shunt_cal), .avg_sel(avg_sel), .run_restart(run_restart),
    .mux_sel(mux_sel), .result(result), .result_valid(result_valid), .run_done(run_done));
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset(input int pre, input int hold);
    repeat (pre) @(posedge core_clk);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (hold) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    `CHK("result", 40'h0, result)
    `CHK("mux_sel", 2'h0, mux_sel)
    // The design forgets its previous current on reset
    prev_cur = 0;
    $display("reset done");
  endtask
  task automatic wait_result(output int cyc);
    cyc = 0;
    do begin
      @(negedge core_clk);
      cyc++;
    end while (result_valid !== 1'b1 && cyc < 30000);
    if (cyc >= 30000) begin
      failures++;
      print_verdict();
    end
  endtask
  // Values change only right after a result, so each run sees one set
  task automatic run_check(input logic [2:0] sel, input int sh, input logic [15:0] s, b, c);
    int cyc;
    longint cur, pw, n;
    n = longint'(1) << sh;
    @(posedge core_clk);
    avg_sel <= sel;
    shunt_val <= s;
    bus_val <= b;
    shunt_cal <= c;
    cur = (longint'(s) * c) >>> 11;
    pw = ((prev_cur * b[14:0]) >>> 8) + (n - 1) * ((cur * b[14:0]) >>> 8);
    if (c == 16'h0000) pw = 0;
    prev_cur = cur;
    wait_result(cyc);
    `CHK("current", 16'((n * cur) >>> sh), result.current)
    `CHK("power", 24'(pw >>> sh), result.power)
    `CHK("early", 1'b1, cyc > (n - 1) * PAIR)
    $display("run sel %0d done", sel);
  endtask
  task automatic t_restart();
    int cyc;
    int start;
    @(posedge core_clk);
    avg_sel <= 3'h1;
    start = bus_cnt;
    cyc = 0;
    while (bus_cnt < start + 2 && cyc < 200) begin
      @(negedge core_clk);
      cyc++;
    end
    if (cyc >= 200) begin
      failures++;
      print_verdict();
    end
    // Clear of the calc that follows the bus sample
    repeat (6) @(posedge core_clk);
    run_restart <= 1'b1;
    @(posedge core_clk);
    run_restart <= 1'b0;
    wait_result(cyc);
    `CHK("restart wait", 1'b1, cyc > 3 * PAIR)
    `CHK("restart cur", 16'(prev_cur), result.current)
    `CHK("restart pwr", 24'((prev_cur * bus_val[14:0]) >>> 8), result.power)
    $display("restart done");
  endtask
  initial begin
    t_reset(0, 4);
    run_check(3'h0, 0, 16'h0400, 16'h0300, 16'h0100);
    run_check(3'h0, 0, 16'h0200, 16'h0500, 16'h0100);
    run_check(3'h0, 0, 16'h0400, 16'h0300, 16'h0000);
    for (int i = 0; i < 8; i++) run_check(3'(i), sh_tab[i], 16'h0400, 16'h0300, 16'h0100);
    t_restart();
    // Second reset lands one pair into a four-sample run
    t_reset(30, 3);
    run_check(3'h1, 2, 16'h0400, 16'h0300, 16'h0100);
    print_verdict();
  end
endmodule // tb_top
